// ---- rtl/sst_pkg.sv ----
// Shared constants and types for the serial shift and test unit
package sst_pkg;
    localparam int         ACC_W      = 24;
    localparam int         CNT_W      = 5;
    localparam logic [4:0] STEP_DONE  = 5'h1F;   // 37 octal
    localparam logic [4:0] STEP_RST   = 5'h00;
    localparam int         FIELD_LSB  = 0;
    localparam int         FIELD_MSB  = 4;
    localparam int         TEST_SHIFT = 24;
    localparam logic [23:0] ACC_RST   = 24'h000000;
    localparam logic [14:0] PC_RST    = 15'h0000;

    typedef enum logic [1:0] {
        SST_SOD = 2'h0,
        SST_SRA = 2'h1,
        SST_SRC = 2'h2,
        SST_SRL = 2'h3
    } sst_cmd_e;

    typedef enum logic [1:0] {
        SST_IDLE  = 2'h0,
        SST_SHIFT = 2'h1,
        SST_DONE  = 2'h3
    } sst_state_e;
endpackage : sst_pkg

// ---- rtl/sst_serial_shift_test_unit.sv ----
// Bit-serial shift and bit-test datapath for execution state 4
//
// How it works
// [RL1] The odd-bit test sets the test flag when the selected bit is one, else leaves it alone.
// [RL2] On start the step counter loads the complement of instruction bits 4 to 0.
// [RL3] The odd-bit test rotates right through the adder, bit 0 into bit 23, for 24 steps.
// [RL4] The odd-bit test counts every shift; at count 37 octal bit 0 is the sampled bit.
// [RL5] For test, arithmetic and circular commands the carry flip-flop stays cleared.
// [RL6] Arithmetic shift keeps bit 23 and copies it into bit 22 each step.
// [RL7] Arithmetic and logical shifts drop bits leaving bit 0, at most 31 places.
// [RL8] Arithmetic shift routes bit 23 through the adder back into bit 23.
// [RL9] Shift commands stop shifting once the counter reaches 37 octal.
// [RL10] Arithmetic and circular shifts count only while the counter is not 37 octal.
// [RL11] Logical shift feeds zeros into bit 23 each step.
// [RL12] Logical shift disables all adder inputs, so the carry stays cleared.
// [RL13] Circular shift passes bit 0 through the adder into bit 23 each step.
// [RL14] On completion the program counter advances by one and interrupts are allowed.
`timescale 1ns/100ps
module sst_serial_shift_test_unit
    import sst_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Command from the sequencer
    input  wire logic              start,
    input  wire logic [1:0]        cmd,
    input  wire logic [23:0]       instrWord,
    // Accumulator and program counter load, test flag clear
    input  wire logic              accLoad,
    input  wire logic [23:0]       accIn,
    input  wire logic              pcLoad,
    input  wire logic [14:0]       pcIn,
    input  wire logic              testClear,
    // Results
    output logic [23:0]            accOut,
    output logic [4:0]             stepCount,
    output logic [14:0]            pcOut,
    output logic                   testFlag,
    output logic                   serialCarryFf,
    output logic                   busy,
    output logic                   done,
    output logic                   interruptAllow
);
    ////////////////////////////////////////////////////////////////////////////
    sst_state_e     state_r;
    sst_cmd_e       cmd_r;
    logic [23:0]    acc_r;
    logic [4:0]     step_r;
    logic [4:0]     testSteps_r;
    logic [14:0]    pc_r;
    logic           test_r;
    logic           carry_r;
    logic           done_r;
    logic           intAllow_r;

    ////////////////////////////////////////////////////////////////////////////
    wire logic      shifting      = (state_r == SST_SHIFT);
    wire logic      atDone        = (step_r == STEP_DONE);
    wire logic      isTest        = (cmd_r == SST_SOD);
    // Test always rotates a full word; shifts stop at 37 octal
    wire logic      testLast      = (testSteps_r == 5'(TEST_SHIFT - 1));
    wire logic      accShiftDriver = shifting && (isTest || !atDone);      // [RL9]
    wire logic      stepIncrementEnable = shifting && (isTest || !atDone); // [RL4] [RL10]
    // Serial adder input gating; the B side is never used here
    wire logic      adderInAGate  = (cmd_r == SST_SRA) ? acc_r[23]         // [RL8]
                                  : (cmd_r == SST_SRL) ? 1'b0              // [RL12]
                                  : acc_r[0];                              // [RL3] [RL13]
    wire logic      adderInBGate  = 1'b0;
    wire logic      adderSum      = adderInAGate ^ adderInBGate ^ carry_r;
    wire logic      adderCarry    = adderInAGate & (adderInBGate | carry_r);
    wire logic [23:0] accShifted  = (cmd_r == SST_SRA)
                                  ? {adderSum, acc_r[23], acc_r[22:1]}     // [RL6] [RL7]
                                  : {adderSum, acc_r[23:1]};               // [RL11] [RL7]
    wire logic      sampleHit     = isTest && shifting && atDone && acc_r[0];
    wire logic      finish        = shifting && (isTest ? testLast : atDone);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r     <= SST_IDLE;
            cmd_r       <= SST_SOD;
            acc_r       <= ACC_RST;
            step_r      <= STEP_RST;
            testSteps_r <= STEP_RST;
            pc_r        <= PC_RST;
            test_r      <= 1'b0;
            carry_r     <= 1'b0;
            done_r      <= 1'b0;
            intAllow_r  <= 1'b1;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                SST_IDLE: begin
                    if (accLoad) begin
                        acc_r <= accIn;
                    end
                    if (pcLoad) begin
                        pc_r <= pcIn;
                    end
                    if (start) begin
                        cmd_r       <= sst_cmd_e'(cmd);
                        step_r      <= ~instrWord[FIELD_MSB:FIELD_LSB]; // [RL2]
                        testSteps_r <= STEP_RST;
                        carry_r     <= 1'b0;                            // [RL5]
                        intAllow_r  <= 1'b0;
                        state_r     <= SST_SHIFT;
                    end
                end
                SST_SHIFT: begin
                    if (accShiftDriver) begin
                        acc_r <= accShifted;
                    end
                    if (stepIncrementEnable) begin
                        step_r <= step_r + 5'h01;
                    end
                    testSteps_r <= testSteps_r + 5'h01;
                    // Carry never sets: no real summation in these commands
                    carry_r <= adderCarry;                               // [RL5] [RL12]
                    if (finish) begin
                        state_r <= SST_DONE;
                    end
                end
                SST_DONE: begin
                    pc_r       <= pc_r + 15'h0001;                       // [RL14]
                    done_r     <= 1'b1;
                    intAllow_r <= 1'b1;                                  // [RL14]
                    state_r    <= SST_IDLE;
                end
                default: begin
                    state_r <= SST_IDLE;
                end
            endcase
            // Set beats the sequencer's clear
            if (sampleHit) begin
                test_r <= 1'b1;                                          // [RL1]
            end else if (testClear) begin
                test_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn) begin
            accOut         <= ACC_RST;
            stepCount      <= STEP_RST;
            pcOut          <= PC_RST;
            testFlag       <= 1'b0;
            serialCarryFf  <= 1'b0;
            busy           <= 1'b0;
            done           <= 1'b0;
            interruptAllow <= 1'b1;
        end else begin
            accOut         <= acc_r;
            stepCount      <= step_r;
            pcOut          <= pc_r;
            testFlag       <= test_r;
            serialCarryFf  <= carry_r;
            busy           <= (state_r != SST_IDLE);
            done           <= done_r;
            interruptAllow <= intAllow_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Adder and carry: none of these commands ever sums
    a_carry_stays_clear: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
        shifting |=> !carry_r)
        else $error("carry set during execution");
    a_srl_gates_off: assert property (@(posedge clk) disable iff (!resetn) // [RL12]
        (shifting && cmd_r == SST_SRL) |-> !adderInAGate && !adderInBGate && !carry_r)
        else $error("adder input live in logical shift");
    a_sra_adder_path: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
        (accShiftDriver && cmd_r == SST_SRA) |-> adderSum == acc_r[23])
        else $error("sign not routed through adder");

    // Step counter
    a_start_loads_step: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
        (state_r == SST_IDLE && start) |=> step_r == ~$past(instrWord[4:0]))
        else $error("step counter not preset");
    a_step_counts_test: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
        (shifting && isTest) |=> step_r == $past(step_r) + 5'h01)
        else $error("test step not counted");
    a_shift_counts: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
        (shifting && !isTest && !atDone) |=> step_r == $past(step_r) + 5'h01)
        else $error("shift step not counted");
    a_stop_at_done: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
        (shifting && !isTest && atDone) |=> $stable(acc_r) && step_r == STEP_DONE)
        else $error("shift past count");

    // Accumulator shape per command
    a_sra_keeps_sign: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
        (accShiftDriver && cmd_r == SST_SRA) |=> acc_r[23] == $past(acc_r[23])
        && acc_r[22] == $past(acc_r[23]))
        else $error("sign not kept");
    a_srl_zero_fill: assert property (@(posedge clk) disable iff (!resetn) // [RL11]
        (accShiftDriver && cmd_r == SST_SRL) |=> !acc_r[23]
        && acc_r[22:0] == $past(acc_r[23:1]))
        else $error("zero not shifted in");
    a_shift_drops_bit0: assert property (@(posedge clk) disable iff (!resetn) // [RL7]
        (accShiftDriver && (cmd_r == SST_SRA || cmd_r == SST_SRL))
        |=> acc_r[21:0] == $past(acc_r[22:1]))
        else $error("low bits not shifted out");
    a_rotate_bit0: assert property (@(posedge clk) disable iff (!resetn) // [RL13]
        (accShiftDriver && cmd_r != SST_SRA && cmd_r != SST_SRL)
        |=> acc_r[23] == $past(acc_r[0]))
        else $error("rotate lost bit");

    // Odd-bit test; compare against the word as it stood after the start edge
    a_test_duration: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
        (state_r == SST_IDLE && start && cmd == SST_SOD)
        |=> ##23 (state_r == SST_SHIFT) ##1 (state_r == SST_DONE))
        else $error("test did not rotate a full word");
    a_test_restores: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
        (state_r == SST_IDLE && start && cmd == SST_SOD) |=> ##24 acc_r == $past(acc_r, 24))
        else $error("test changed accumulator");

    // Test flag
    a_test_sets_flag: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
        sampleHit |=> test_r)
        else $error("test flag not set");
    a_flag_untouched: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
        (shifting && !sampleHit && !testClear) |=> test_r == $past(test_r))
        else $error("test flag changed without a hit");

    // Completion
    a_pc_advances: assert property (@(posedge clk) disable iff (!resetn) // [RL14]
        (state_r == SST_DONE) |=> pc_r == $past(pc_r) + 15'h0001 && intAllow_r)
        else $error("pc not advanced");
endmodule : sst_serial_shift_test_unit

// ---- dv/sst_seq_model.sv ----
// Sequencer model issuing single-word shift and test commands
`timescale 1ns/100ps
module sst_seq_model
    import sst_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Command to the unit
    output logic             start,
    output logic [1:0]       cmd,
    output logic [23:0]      instrWord,
    // Completion from the unit
    input  wire logic        done
);
    initial begin
        start = 1'b0;
        cmd = 2'h0;
        instrWord = 24'h000000;
    end
    ////////////////////////////////////////////////////////////////////////
    // Upper word bits are busy on purpose; only the field may matter
    task automatic issue(input logic [1:0] c, input logic [4:0] z, input bit rude,
                         output bit ok);
        @(posedge clk);
        start <= 1'b1;
        cmd <= c;
        instrWord <= {19'h2A5A5, z};
        @(posedge clk);
        start <= 1'b0;
        if (rude) begin
            repeat (2) @(posedge clk);
            start <= 1'b1;
            cmd <= SST_SRL;
            instrWord <= 24'h00001F;
            @(posedge clk);
            start <= 1'b0;
        end
        ok = 1'b0;
        for (int i = 0; i < 80 && !ok; i++) begin
            @(posedge clk);
            ok = (done === 1'b1);
        end
    endtask : issue
endmodule : sst_seq_model

// ---- dv/testbench.sv ----
// Self-checking bench for the serial shift and test unit
`timescale 1ns/100ps
module testbench;
    import sst_pkg::*;
    typedef struct {logic [1:0] c; logic [4:0] z; logic [23:0] a, e; logic f, k;} sst_row_s;
    logic clk = 1'b0, resetn = 1'b0, start, accLoad = 1'b0, pcLoad = 1'b0, testClear = 1'b0;
    logic [1:0] cmd;
    logic [23:0] instrWord, accIn = 24'h000000, accOut;
    logic [14:0] pcIn = 15'h7FFE, pcOut, expPc = 15'h7FFE;
    logic [4:0] stepCount;
    logic testFlag, serialCarryFf, busy, done, interruptAllow;
    int fails = 0, check_count = 0, cycles = 0;
    bit okBg;
    sst_row_s rows [12] = '{
        '{SST_SOD, 5'h05, 24'h000020, 24'h000020, 1'b1, 1'b1},
        '{SST_SOD, 5'h17, 24'h7FFFFF, 24'h7FFFFF, 1'b0, 1'b1},
        '{SST_SOD, 5'h00, 24'h000001, 24'h000001, 1'b1, 1'b1},
        '{SST_SOD, 5'h17, 24'h7FFFFF, 24'h7FFFFF, 1'b1, 1'b0},
        '{SST_SRA, 5'h04, 24'h800F00, 24'hF800F0, 1'b0, 1'b1},
        '{SST_SRA, 5'h18, 24'h812345, 24'hFFFFFF, 1'b0, 1'b1},
        '{SST_SRA, 5'h00, 24'h123456, 24'h123456, 1'b0, 1'b1},
        '{SST_SRA, 5'h03, 24'h400008, 24'h080001, 1'b0, 1'b1},
        '{SST_SRC, 5'h08, 24'h123456, 24'h561234, 1'b0, 1'b1},
        '{SST_SRC, 5'h17, 24'h000001, 24'h000002, 1'b0, 1'b1},
        '{SST_SRL, 5'h03, 24'h800008, 24'h100001, 1'b0, 1'b1},
        '{SST_SRL, 5'h18, 24'hFFFFFF, 24'h000000, 1'b0, 1'b1}};
    sst_serial_shift_test_unit i_sst_serial_shift_test_unit (.clk(clk), .resetn(resetn),
        .start(start), .cmd(cmd), .instrWord(instrWord), .accLoad(accLoad), .accIn(accIn),
        .pcLoad(pcLoad), .pcIn(pcIn), .testClear(testClear), .accOut(accOut),
        .stepCount(stepCount), .pcOut(pcOut), .testFlag(testFlag),
        .serialCarryFf(serialCarryFf), .busy(busy), .done(done),
        .interruptAllow(interruptAllow));
    sst_seq_model i_sst_seq_model (.clk(clk), .start(start), .cmd(cmd),
        .instrWord(instrWord), .done(done));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Extra start mid-run must be ignored, so expectations stay those of the row
    task automatic run_row(input sst_row_s r, input bit rude);
        bit ok;
        @(posedge clk);
        testClear <= r.k;
        accLoad <= 1'b1;
        accIn <= r.a;
        @(posedge clk);
        testClear <= 1'b0;
        accLoad <= 1'b0;
        i_sst_seq_model.issue(r.c, r.z, rude, ok);
        @(posedge clk);
        expPc = expPc + 15'h0001;
        check(24'(ok), 24'h000001);
        check(accOut, r.e);
        check(24'(testFlag), 24'(r.f));
        check(24'(stepCount), 24'(r.c == SST_SOD ? 5'h17 - r.z : STEP_DONE));
        check(24'(serialCarryFf), 24'h000000);
        check(24'(pcOut), 24'(expPc));
        check(24'(interruptAllow), 24'h000001);
    endtask : run_row
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        pcLoad <= 1'b1;
        @(posedge clk);
        pcLoad <= 1'b0;
        foreach (rows[i]) run_row(rows[i], 1'b0);
        run_row('{SST_SRC, 5'h04, 24'h00000F, 24'hF00000, 1'b0, 1'b1}, 1'b1);
        fork
            i_sst_seq_model.issue(SST_SRL, 5'h1F, 1'b0, okBg);
        join_none
        repeat (6) @(posedge clk);
        // Two shifts of the last result are visible, command still running
        check(24'({busy, interruptAllow}), 24'h000002);
        check(accOut, 24'h3C0000);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        check(accOut, ACC_RST);
        check(24'(pcOut), 24'(PC_RST));
        check(24'({busy, testFlag, interruptAllow}), 24'h000001);
        // Unit must work again after the mid-run reset, counting from the reset pc
        resetn <= 1'b1;
        expPc = PC_RST;
        run_row('{SST_SRL, 5'h01, 24'h000002, 24'h000001, 1'b0, 1'b0}, 1'b0);
        give_verdict();
    end
endmodule : testbench
